//--- rtl/flash_host.sv
// Host controller that drives the serial flash through its clock, data and select pins
`timescale 1ns/10ps
module flash_host
  import flash_host_pkg::*;
#(
  parameter int DEPTH = 32,
  parameter logic [2:0] CHIP_ADDR = 3'h0
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [7:0] cmd_opcode,
  input wire logic [2:0] cmd_kind,
  input wire logic [15:0] cmd_field_a,
  input wire logic [15:0] cmd_field_b,
  input wire logic [8:0] cmd_count,
  input wire logic cmd_pad_word,
  input wire logic cmd_reset,
  input wire logic wdata_valid,
  output logic wdata_ready,
  input wire logic [7:0] wdata,
  output logic rdata_valid,
  input wire logic rdata_ready,
  output logic [7:0] rdata,
  output logic [15:0] last_word,
  output logic device_busy,
  output logic integrity_error,
  output logic restricted_refused,
  output logic done_pulse,
  output logic sck,
  output logic cs_n,
  input wire logic serial_io_in,
  output logic serial_io_out,
  output logic serial_io_oe
);
  // ==========================================================
  // State and registers
  typedef enum logic [3:0] {
    S_IDLE, S_RST_HI, S_RST_LO, S_HEAD, S_FIELD_A, S_FIELD_B, S_PAD,
    S_WDATA, S_RDATA, S_POLL, S_END
  } state_e;
  state_e state_reg, state_next;
  logic [15:0] shift_reg, shift_next;      // Outgoing or incoming bits
  logic [4:0] bit_reg, bit_next;           // Bits left in current unit
  logic [CNT_W-1:0] left_reg, left_next;   // Bytes or words left
  logic [DIV_W-1:0] div_reg, div_next;     // Link clock divider
  logic sck_reg, sck_next;
  logic cs_n_reg, cs_n_next;
  logic oe_reg, oe_next;
  logic [7:0] op_reg, op_next;
  logic [2:0] kind_reg, kind_next;
  logic [15:0] fa_reg, fa_next;            // First field to send
  logic [15:0] fb_reg, fb_next;
  logic pad_reg, pad_next;
  logic [15:0] word_reg, word_next;
  logic done_reg, done_next;
  logic refused_reg, refused_next;
  logic [7:0] rd_byte_reg, rd_byte_next;
  logic rd_push;
  logic push_reg;                          // Completed read byte waits to be stored
  logic rfifo_in_ready;
  logic sio_meta_reg, sio_sync_reg;        // Input synchroniser
  logic rise, fall;
  logic restricted;

  // Input synchroniser; first stage read only by the second
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sio_meta_reg <= 1'b0;
      sio_sync_reg <= 1'b0;
    end else begin
      sio_meta_reg <= serial_io_in;
      sio_sync_reg <= sio_meta_reg;
    end
  end

  // ==========================================================
  // Read data FIFO; full FIFO stalls the link clock
  word_fifo #(.WIDTH(BYTE_W), .DEPTH(DEPTH)) u_rfifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_valid(rd_push),
    .in_ready(rfifo_in_ready),
    .in_data(rd_byte_reg),
    .out_valid(rdata_valid),
    .out_ready(rdata_ready),
    .out_data(rdata)
  );

  // Busy-restricted opcodes
  always_comb begin
    case (cmd_opcode)
      OP_XFER_SEC_SRAM0, OP_XFER_SEC_SRAM1, OP_WR_SECTOR0, OP_WR_SECTOR1,
      OP_COPY_0_TO_1, OP_COPY_1_TO_0, OP_REFRESH0, OP_REFRESH1, OP_READ_INFO,
      OP_WRITE_CONFIG: restricted = 1'b1;
      default: restricted = 1'b0;
    endcase
  end

  // ==========================================================
  // Frame sequencer: next-state logic
  always_comb begin
    state_next = state_reg;
    shift_next = shift_reg;
    bit_next = bit_reg;
    left_next = left_reg;
    div_next = div_reg;
    sck_next = sck_reg;
    cs_n_next = cs_n_reg;
    oe_next = oe_reg;
    op_next = op_reg;
    kind_next = kind_reg;
    fa_next = fa_reg;
    fb_next = fb_reg;
    pad_next = pad_reg;
    word_next = word_reg;
    done_next = 1'b0;
    refused_next = 1'b0;
    rd_byte_next = rd_byte_reg;
    rd_push = push_reg;
    rise = 1'b0;
    fall = 1'b0;
    cmd_ready = (state_reg == S_IDLE);
    wdata_ready = 1'b0;
    // Divider toggles the link clock, held while read FIFO is full
    if (state_reg inside {S_HEAD, S_FIELD_A, S_FIELD_B, S_PAD, S_WDATA, S_RDATA, S_POLL}) begin
      if (div_reg == DIV_W'(SCK_HALF_CYC - 1)) begin
        if (rfifo_in_ready) begin
          div_next = '0;
          sck_next = !sck_reg;
          rise = !sck_reg;
          fall = sck_reg;
        end
      end else begin
        div_next = div_reg + 1'b1;
      end
    end
    case (state_reg)
      S_IDLE: begin
        cs_n_next = 1'b1;
        sck_next = 1'b0;
        oe_next = 1'b0;
        if (cmd_valid) begin
          if (cmd_reset) begin
            state_next = S_RST_LO;
            cs_n_next = 1'b0;
            div_next = cmd_field_a[CFG_RST_BIT] ? DIV_W'(RESET_LONG_CYC) : DIV_W'(RESET_SHORT_CYC);
          end else if (restricted && device_busy) begin
            refused_next = 1'b1;
          end else begin
            shift_next = {SEL_UPPER_ZERO, CHIP_ADDR, cmd_opcode};
            bit_next = 5'(WORD_W);
            op_next = cmd_opcode;
            kind_next = cmd_kind;
            fa_next = (cmd_opcode == OP_WRITE_CONFIG) ? (cmd_field_a & CONFIG_USED_MASK)
                                                      : cmd_field_a;
            fb_next = cmd_field_b;
            pad_next = cmd_pad_word;
            left_next = cmd_count;
            div_next = '0;
            cs_n_next = 1'b0;
            oe_next = 1'b1;
            state_next = S_HEAD;
          end
        end
      end
      S_RST_LO: begin
        if (div_reg == '0) begin
          cs_n_next = 1'b1;
          state_next = S_IDLE;
          done_next = 1'b1;
        end else begin
          div_next = div_reg - 1'b1;
        end
      end
      S_HEAD, S_FIELD_A, S_FIELD_B, S_PAD, S_WDATA: begin
        // Data changes on falling edge, device samples on rising edge
        if (rise) begin
          bit_next = bit_reg - 1'b1;
        end else if (fall) begin
          shift_next = {shift_reg[14:0], 1'b0};
          if (bit_reg == '0) begin
            case (state_reg)
              S_HEAD: begin
                // Bare opcodes end here, status and config reads poll next; every other opcode carries its fields
                state_next = (op_reg inside {OP_WRITE_EN, OP_WRITE_DIS, OP_PWR_SET,
                                             OP_PWR_CLEAR}) ? S_END : S_FIELD_A;
                shift_next = fa_reg;
                bit_next = 5'(WORD_W);
                if (op_reg == OP_READ_CONFIG || op_reg == OP_READ_STATUS) begin
                  oe_next = 1'b0;
                  state_next = S_POLL;
                  left_next = CNT_W'(1);
                end
              end
              S_FIELD_A: begin
                shift_next = fb_reg;
                // byte read has eight control clocks, not sixteen
                bit_next = (kind_reg == KIND_READ) ? 5'(BYTE_W) : 5'(WORD_W);
                state_next = S_FIELD_B;
              end
              S_FIELD_B: begin
                if (kind_reg == KIND_WRITE) begin
                  state_next = S_WDATA;
                  bit_next = '0;
                  shift_next = '0;
                end else if (pad_reg) begin
                  shift_next = '0;
                  bit_next = 5'(WORD_W);
                  state_next = S_PAD;
                end else begin
                  state_next = (kind_reg == KIND_READ) ? S_RDATA : S_END;
                  oe_next = (kind_reg != KIND_READ);
                  bit_next = 5'(BYTE_W);
                  if (kind_reg == KIND_POLL) begin
                    state_next = S_POLL;
                    oe_next = 1'b0;
                    bit_next = 5'(WORD_W);
                  end
                end
              end
              S_PAD: begin
                state_next = (kind_reg == KIND_POLL) ? S_POLL : S_END;
                oe_next = 1'b0;
                bit_next = 5'(WORD_W);
              end
              default: begin
                // Write data bytes until the count or the data runs out, then end with no closing byte
                if (left_reg == '0) begin
                  state_next = S_END;
                end else if (wdata_valid) begin
                  wdata_ready = 1'b1;
                  shift_next = {wdata, 8'h00};
                  bit_next = 5'(BYTE_W);
                  left_next = left_reg - 1'b1;
                end else begin
                  bit_next = 5'(BYTE_W);
                  shift_next = '0;
                  state_next = S_END;
                end
              end
            endcase
          end
        end
      end
      S_RDATA, S_POLL: begin
        // Sample incoming bit on rising edge
        if (rise) begin
          shift_next = {shift_reg[14:0], sio_sync_reg};
          bit_next = bit_reg - 1'b1;
          if (bit_reg == 5'(1)) begin
            left_next = left_reg - 1'b1;
            if (state_reg == S_RDATA) begin
              rd_byte_next = {shift_reg[6:0], sio_sync_reg};
              bit_next = 5'(BYTE_W);
            end else begin
              word_next = {shift_reg[14:0], sio_sync_reg};
              bit_next = 5'(WORD_W);
            end
          end
        end else if (fall && left_reg == '0) begin
          // Close only with the clock low again, so its high phase stays whole
          state_next = S_END;
        end
      end
      S_END: begin
        // rising select ends and resets command
        cs_n_next = 1'b1;
        sck_next = 1'b0;
        oe_next = 1'b0;
        done_next = 1'b1;
        state_next = S_IDLE;
      end
      default: state_next = S_IDLE;
    endcase
  end

  // Byte capture pulse: push one cycle after a completed read byte
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      push_reg <= 1'b0;
    end else begin
      push_reg <= (state_reg == S_RDATA) && rise && (bit_reg == 5'(1));
    end
  end
  assign last_word = word_reg;

  // ==========================================================
  // Register stage of the sequencer
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= S_IDLE;
      shift_reg <= '0;
      bit_reg <= '0;
      left_reg <= '0;
      div_reg <= '0;
      sck_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      oe_reg <= 1'b0;
      op_reg <= '0;
      kind_reg <= KIND_PLAIN;
      fa_reg <= '0;
      fb_reg <= '0;
      pad_reg <= 1'b0;
      word_reg <= '0;
      done_reg <= 1'b0;
      refused_reg <= 1'b0;
      rd_byte_reg <= '0;
    end else begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      bit_reg <= bit_next;
      left_reg <= left_next;
      div_reg <= div_next;
      sck_reg <= sck_next;
      cs_n_reg <= cs_n_next;
      oe_reg <= oe_next;
      op_reg <= op_next;
      kind_reg <= kind_next;
      fa_reg <= fa_next;
      fb_reg <= fb_next;
      pad_reg <= pad_next;
      word_reg <= word_next;
      done_reg <= done_next;
      refused_reg <= refused_next;
      rd_byte_reg <= rd_byte_next;
    end
  end

  // ==========================================================
  // Pin and status outputs
  always_comb begin
    sck = sck_reg;
    cs_n = cs_n_reg;
    serial_io_oe = oe_reg;
    serial_io_out = shift_reg[15];
    done_pulse = done_reg;
    restricted_refused = refused_reg;
    device_busy = word_reg[ST_BUSY_BIT] | word_reg[ST_XFER_HI_BIT] | word_reg[ST_XFER_LO_BIT];
    integrity_error = (word_reg[ST_DI_HI_BIT:ST_DI_LO_BIT] == DI_ERROR);
  end
endmodule : flash_host

//--- rtl/flash_host_pkg.sv
// Package of opcodes, field layouts and timing constants for the serial flash host
package flash_host_pkg;
  // ==========================================================
  // Frame field widths and byte count width
  localparam int BYTE_W = 8;
  localparam int WORD_W = 16;
  localparam int CNT_W = 9;
  // ==========================================================
  // Opcodes
  localparam logic [7:0] OP_XFER_SEC_SRAM0 = 8'h5C;
  localparam logic [7:0] OP_XFER_SEC_SRAM1 = 8'h5D;
  localparam logic [7:0] OP_READ_SRAM0 = 8'h71;
  localparam logic [7:0] OP_READ_SRAM1 = 8'h73;
  localparam logic [7:0] OP_WRITE_EN = 8'h06;
  localparam logic [7:0] OP_WRITE_DIS = 8'h04;
  localparam logic [7:0] OP_WR_SECTOR0 = 8'hF6;
  localparam logic [7:0] OP_WR_SECTOR1 = 8'h98;
  localparam logic [7:0] OP_WR_SRAM0 = 8'h72;
  localparam logic [7:0] OP_WR_SRAM1 = 8'h74;
  localparam logic [7:0] OP_COPY_0_TO_1 = 8'h92;
  localparam logic [7:0] OP_COPY_1_TO_0 = 8'h55;
  localparam logic [7:0] OP_REFRESH0 = 8'h58;
  localparam logic [7:0] OP_REFRESH1 = 8'h59;
  localparam logic [7:0] OP_READ_INFO = 8'h15;
  localparam logic [7:0] OP_READ_CONFIG = 8'h8C;
  localparam logic [7:0] OP_WRITE_CONFIG = 8'h8A;
  localparam logic [7:0] OP_READ_STATUS = 8'h84;
  localparam logic [7:0] OP_PWR_CLEAR = 8'h09;
  localparam logic [7:0] OP_PWR_SET = 8'h03;
  // ==========================================================
  // Device select layout
  localparam logic [4:0] SEL_UPPER_ZERO = 5'h00;
  // ==========================================================
  // Configuration layout and shipped value
  localparam logic [15:0] CONFIG_SHIPPED = 16'h0009;
  localparam logic [15:0] CONFIG_USED_MASK = 16'h01FF;
  localparam int CFG_RST_BIT = 0;
  localparam int CFG_DIR_BIT = 3;
  localparam int CFG_RANGE_LSB = 4;
  localparam int CFG_RANGE_MSB = 7;
  // ==========================================================
  // Status layout
  localparam int ST_BUSY_BIT = 15;
  localparam int ST_XFER_HI_BIT = 14;
  localparam int ST_XFER_LO_BIT = 13;
  localparam int ST_WEN_BIT = 12;
  localparam int ST_PWR_BIT = 8;
  localparam int ST_DI_HI_BIT = 1;
  localparam int ST_DI_LO_BIT = 0;
  localparam logic [1:0] DI_ERROR = 2'h3;
  // ==========================================================
  // Timing: reset pulse windows in ns and link clock divider
  localparam int RESET_SHORT_MIN_NS = 1500;
  localparam int RESET_LONG_MIN_NS = 5000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int RESET_SHORT_CYC = (RESET_SHORT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_LONG_CYC = (RESET_LONG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCK_HALF_CYC = 4;
  localparam int DIV_W = 12;
  // ==========================================================
  // Command kinds taken at the user port
  localparam logic [2:0] KIND_PLAIN = 3'h0;
  localparam logic [2:0] KIND_READ = 3'h1;
  localparam logic [2:0] KIND_WRITE = 3'h2;
  localparam logic [2:0] KIND_POLL = 3'h3;
endpackage : flash_host_pkg

//--- rtl/word_fifo.sv
// Flip-flop FIFO with valid and ready on both sides
`timescale 1ns/10ps
module word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  // ==========================================================
  // Storage and pointers
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg, wr_next;
  logic [AW-1:0] rd_reg, rd_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic push, pop;

  // Handshakes and pointer advance
  always_comb begin
    in_ready = (cnt_reg != (AW+1)'(DEPTH));
    out_valid = (cnt_reg != '0);
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wr_next = push ? AW'(wr_reg + 1'b1) : wr_reg;
    rd_next = pop ? AW'(rd_reg + 1'b1) : rd_reg;
    cnt_next = cnt_reg;
    if (push && !pop) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 1'b1;
    end
    out_data = mem_reg[rd_reg];
  end

  // Pointer registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  // Storage write, no reset needed
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end
endmodule : word_fifo

//--- test/flash_host_asserts.sv
// Port checker for the serial flash host controller
`timescale 1ns/10ps
module flash_host_asserts
  import flash_host_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic [15:0] last_word,
  input wire logic device_busy,
  input wire logic integrity_error,
  input wire logic restricted_refused,
  input wire logic done_pulse,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic serial_io_oe
);
  // ==========================================================
  // Single clock domain
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_busy_from_word: assert property (device_busy == last_word[ST_BUSY_BIT])
    else $error("busy flag differs from status word");
  a_integrity_code: assert property (integrity_error == (last_word[1:0] == DI_ERROR))
    else $error("integrity flag differs from status word");
  a_sck_half_period: assert property ($rose(sck) |-> sck[*4] ##1 !sck)
    else $error("link clock high phase not four cycles");
  a_frame_select_low: assert property ($fell(cs_n) |-> !cs_n[*8])
    else $error("select pulse too short");
  a_drive_in_frame: assert property (serial_io_oe |-> !cs_n)
    else $error("data line driven outside a frame");
  a_ready_when_idle: assert property (cmd_ready |-> cs_n)
    else $error("command taken during a frame");
  a_refuse_only_busy: assert property (restricted_refused |-> device_busy)
    else $error("refusal while device ready");
  a_take_starts_frame: assert property (
    cmd_valid && cmd_ready && !device_busy |-> ##[1:16] !cs_n)
    else $error("accepted command opened no frame");
  cover property (done_pulse);
  cover property (restricted_refused);
  cover property (integrity_error && device_busy);
endmodule : flash_host_asserts

bind flash_host flash_host_asserts u_flash_host_asserts (
  .clk_sys(clk_sys), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
  .last_word(last_word), .device_busy(device_busy), .integrity_error(integrity_error),
  .restricted_refused(restricted_refused), .done_pulse(done_pulse), .sck(sck),
  .cs_n(cs_n), .serial_io_oe(serial_io_oe)
);

//--- test/flash_dev_model.sv
// Behavioural model of the serial flash device beyond the host
`timescale 1ns/10ps
module flash_dev_model
  import flash_host_pkg::*;
#(
  parameter logic [2:0] PIN_ADDR = 3'h0,
  parameter int BUSY_READS = 1
) (
  input wire logic sck,
  input wire logic cs_n,
  input wire logic sio_in,
  input wire logic [1:0] di_code,
  output logic sio_out,
  output logic sio_oe,
  output logic [15:0] config_bits
);
  logic [15:0] shift_word; // Bits taken from the line
  logic [15:0] tx_word; // Word being sent back
  logic [15:0] status_word; // Live status
  logic [7:0] opcode;
  logic sel_hit, wr_en, pwr_flag, xfer;
  int nbit, reads_left;
  initial begin
    config_bits = CONFIG_SHIPPED;
    {sel_hit, wr_en, pwr_flag, xfer, sio_oe, sio_out} = 6'h01;
    nbit = 0;
    reads_left = 0;
  end
  assign status_word = {xfer, xfer, xfer, wr_en, 3'h0, pwr_flag, 6'h00, di_code};
  // shift in select, opcode and fields
  always @(posedge sck) begin
    if (!cs_n) begin
      shift_word = {shift_word[14:0], sio_in};
      nbit = nbit + 1;
      if (nbit == 8) sel_hit = (shift_word[7:0] == {SEL_UPPER_ZERO, PIN_ADDR});
      if (nbit == 16) begin
        opcode = shift_word[7:0];
        tx_word = (opcode == OP_READ_STATUS) ? status_word : config_bits;
        if (sel_hit && opcode == OP_READ_STATUS && xfer) begin
          reads_left = reads_left - 1;
          xfer = (reads_left > 0);
        end
      end
      if (nbit == 32 && sel_hit && opcode == OP_WRITE_CONFIG && !xfer) config_bits = shift_word;
    end
  end
  // word goes out MSB first after the opcode
  always @(negedge sck) begin
    sio_oe = !cs_n && sel_hit && nbit >= 16 && nbit < 32 &&
      (opcode == OP_READ_STATUS || opcode == OP_READ_CONFIG);
    if (sio_oe) sio_out = tx_word[31 - nbit];
  end
  // select rise ends the frame; unknown opcodes change nothing
  always @(posedge cs_n) begin
    if (sel_hit && nbit >= 16) begin
      if (opcode == OP_WRITE_EN) wr_en = 1'b1;
      if (opcode == OP_WRITE_DIS) wr_en = 1'b0;
      if (opcode == OP_PWR_SET) pwr_flag = 1'b1;
      if (opcode == OP_PWR_CLEAR) pwr_flag = 1'b0;
      if (opcode inside {OP_XFER_SEC_SRAM0, OP_XFER_SEC_SRAM1, OP_REFRESH0, OP_REFRESH1}) begin
        xfer = 1'b1;
        reads_left = BUSY_READS;
      end
    end
    nbit = 0;
    sel_hit = 1'b0;
    sio_oe = 1'b0;
  end
endmodule : flash_dev_model

//--- test/tb_top.sv
// Bench for the serial flash host with a device model
`timescale 1ns/10ps
module tb_top
  import flash_host_pkg::*;
();
  typedef struct packed {logic [7:0] op; logic [15:0] fa; logic pad; logic rd; logic [15:0] exp;} row_s;
  localparam int SHORT_MAX = 5000 / CLK_PERIOD_NS;
  localparam int LONG_MAX = 10000 / CLK_PERIOD_NS;
  logic clk_sys = 0, rst_n = 0, cmd_valid = 0, cmd_reset = 0, cmd_pad_word = 0, rdata_ready = 0;
  logic [8:0] cmd_count = 9'h001;
  logic [7:0] cmd_opcode = 8'h00, rdata;
  logic [2:0] cmd_kind = 3'h0;
  logic [15:0] cmd_field_a = 16'h0000, cmd_field_b = 16'h0000, last_word, cfg_seen;
  logic [1:0] di_code = 2'h0;
  logic cmd_ready, rdata_valid, device_busy, integrity_error, restricted_refused, done_pulse;
  logic sck, cs_n, sio_out, sio_oe, dev_out, dev_oe, sio_wire, wdata_ready, saw_done, saw_ref;
  int n_fail = 0, n_tests = 0, low_cyc;
  // rows read the configuration before writing a new value
  row_s rows [9] = '{
    '{OP_READ_CONFIG, 16'h0000, 1'b0, 1'b1, CONFIG_SHIPPED}, '{OP_WRITE_CONFIG, 16'h00A1, 1'b0, 1'b0, 16'h0000},
    '{OP_READ_CONFIG, 16'h0000, 1'b0, 1'b1, 16'h00A1}, '{OP_WRITE_EN, 16'h0000, 1'b0, 1'b0, 16'h0000},
    '{OP_READ_STATUS, 16'h0000, 1'b0, 1'b1, 16'h1000}, '{OP_PWR_SET, 16'h0000, 1'b0, 1'b0, 16'h0000},
    '{OP_READ_STATUS, 16'h0000, 1'b0, 1'b1, 16'h1100}, '{OP_WRITE_DIS, 16'h0000, 1'b0, 1'b0, 16'h0000},
    '{OP_READ_STATUS, 16'h0000, 1'b0, 1'b1, 16'h0100}};
  always #12.5 clk_sys = ~clk_sys;
  // Pull-up holds the data line when nobody drives it
  assign sio_wire = sio_oe ? sio_out : (dev_oe ? dev_out : 1'b1);
  flash_host #(.CHIP_ADDR(3'h5)) u_flash_host (.clk_sys(clk_sys), .rst_n(rst_n),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_opcode(cmd_opcode), .cmd_kind(cmd_kind),
    .cmd_field_a(cmd_field_a), .cmd_field_b(cmd_field_b), .cmd_count(cmd_count),
    .cmd_pad_word(cmd_pad_word), .cmd_reset(cmd_reset), .wdata_valid(1'b0),
    .wdata_ready(wdata_ready), .wdata(8'h00), .rdata_valid(rdata_valid),
    .rdata_ready(rdata_ready),
    .rdata(rdata), .last_word(last_word), .device_busy(device_busy),
    .integrity_error(integrity_error), .restricted_refused(restricted_refused),
    .done_pulse(done_pulse), .sck(sck), .cs_n(cs_n), .serial_io_in(sio_wire),
    .serial_io_out(sio_out), .serial_io_oe(sio_oe));
  flash_dev_model #(.PIN_ADDR(3'h5)) u_flash_dev_model (.sck(sck), .cs_n(cs_n),
    .sio_in(sio_wire), .di_code(di_code), .sio_out(dev_out), .sio_oe(dev_oe),
    .config_bits(cfg_seen));
  // ==========================================================
  // Compare, verdict and command tasks
  task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word
  task automatic chk_flag(input string what, input logic exp, input logic got);
    chk_word(what, {15'h0000, exp}, {15'h0000, got});
  endtask : chk_flag
  task automatic print_verdict;
    if (n_fail == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict
  // One command: hold valid until taken, then wait for idle again
  task automatic run(input logic [7:0] op, input logic [2:0] kind, input logic [15:0] fa,
    input logic pad, input logic rst);
    int i;
    cmd_opcode = op;
    cmd_kind = kind;
    cmd_field_a = fa;
    cmd_pad_word = pad;
    cmd_reset = rst;
    cmd_valid = 1'b1;
    for (i = 0; i < 100 && cmd_ready !== 1'b1; i++) @(posedge clk_sys) #1;
    if (i == 100) begin
      n_fail++;
      print_verdict();
    end
    @(posedge clk_sys) #1;
    cmd_valid = 1'b0;
    low_cyc = 0;
    saw_done = 1'b0;
    saw_ref = 1'b0;
    for (i = 0; i < 6000; i++) begin
      low_cyc += (cs_n === 1'b0);
      saw_done |= (done_pulse === 1'b1);
      saw_ref |= (restricted_refused === 1'b1);
      if (i > 0 && cmd_ready === 1'b1 && cs_n === 1'b1) break;
      @(posedge clk_sys) #1;
    end
    @(posedge clk_sys) #1;
    saw_done |= (done_pulse === 1'b1);
    if (i == 6000) begin
      n_fail++;
      print_verdict();
    end
  endtask : run
  // ==========================================================
  // Main sequence
  initial begin
    repeat (3) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    run(8'h00, KIND_PLAIN, 16'h0000, 1'b0, 1'b1);
    chk_flag("short reset", 1'b1, low_cyc >= RESET_SHORT_CYC && low_cyc <= SHORT_MAX);
    run(8'h00, KIND_PLAIN, 16'h0001, 1'b0, 1'b1);
    chk_flag("long reset", 1'b1, low_cyc >= RESET_LONG_CYC && low_cyc <= LONG_MAX);
    for (int r = 0; r < 9; r++) begin
      run(rows[r].op, rows[r].rd ? KIND_POLL : KIND_PLAIN, rows[r].fa, rows[r].pad, 1'b0);
      if (rows[r].rd) chk_word("row word", rows[r].exp, last_word);
    end
    chk_flag("frame done", 1'b1, saw_done);
    di_code = 2'h3;
    run(OP_XFER_SEC_SRAM0, KIND_PLAIN, 16'h0123, 1'b1, 1'b0);
    run(OP_READ_STATUS, KIND_POLL, 16'h0000, 1'b0, 1'b0);
    chk_word("status in transfer", 16'hE103, last_word);
    chk_flag("busy flag", 1'b1, device_busy);
    chk_flag("integrity flag", 1'b1, integrity_error);
    run(OP_WRITE_CONFIG, KIND_PLAIN, 16'h0000, 1'b1, 1'b0);
    chk_flag("config write refused", 1'b1, saw_ref);
    run(OP_REFRESH0, KIND_PLAIN, 16'h0040, 1'b1, 1'b0);
    chk_flag("refresh refused", 1'b1, saw_ref);
    di_code = 2'h1;
    run(OP_READ_STATUS, KIND_POLL, 16'h0000, 1'b0, 1'b0);
    chk_word("status after transfer", 16'h0101, last_word);
    chk_flag("busy clear", 1'b0, device_busy);
    chk_flag("integrity clear", 1'b0, integrity_error);
    run(OP_READ_CONFIG, KIND_POLL, 16'h0000, 1'b0, 1'b0);
    chk_word("config kept", 16'h00A1, last_word);
    // Released line reads high through the pull-up; the byte waits in the FIFO
    run(OP_READ_SRAM0, KIND_READ, 16'h0000, 1'b0, 1'b0);
    chk_flag("read byte valid", 1'b1, rdata_valid);
    chk_word("read byte", 16'h00FF, {8'h00, rdata});
    rdata_ready = 1'b1;
    @(posedge clk_sys) #1;
    chk_flag("read byte taken", 1'b0, rdata_valid);
    print_verdict();
  end
endmodule : tb_top
